// ==== hw/gpio_format_config.v ====
// Pin configuration word with per-pin static or pulse-width signalling.
// Assumes count, time-base and output data settings come from sibling
// registers on the same clock; pin inputs come from outside and are
// synchronised here.
`timescale 1ns/10ps
`include "gpio_format_config_defines.vh"

// Summary of operation
// - Configuration word at 4Dh, 16 bits, cleared to zero on reset.
// - Bit 15 is read-only and always reads zero.
// - Bits 14..10 select format per pin, pin 4 at bit 14.
// - Format 0 input: level taken straight from the pin.
// - Format 0 output: static level, pulse counts ignored.
// - Format 1 input: level decoded from pulse-width waveform.
// - Format 1 output: pulse waveform from low/high count settings.
// - Format 0 readback of driven pin uses static interpretation.
// - Format 1 readback decodes pulses using the pin's own time base.
// - Direction bit 0 means input, 1 means output.
// - Source bit 0 selects alternate signal, 1 selects output data.
// - Bit 1 reserved, read-only, reads zero; pin 1 has no alternate.
module gpio_format_config #(
   parameter PINS = 5
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] addr_i,
   input wire wr_en_i,
   input wire [15:0] wdata_i,
   output reg [15:0] rdata_o,
   input wire [PINS-1:0] output_data_i,
   input wire [PINS-1:0] alt_signal_i,
   input wire [PINS*`CNT_W-1:0] low_code_high_count_i,
   input wire [PINS*`CNT_W-1:0] low_code_low_count_i,
   input wire [PINS*`CNT_W-1:0] high_code_high_count_i,
   input wire [PINS*`CNT_W-1:0] high_code_low_count_i,
   input wire [PINS*2-1:0] time_base_i,
   input wire [PINS-1:0] pin_i,
   output reg [PINS-1:0] pin_o,
   output reg [PINS-1:0] pin_oe_n_o,
   output reg [PINS-1:0] input_level_o,
   output reg [PINS-1:0] readback_level_o,
   output reg [PINS-1:0] readback_mismatch_o
);

   // ---------------------------------------------------------------
   // Configuration word
   // ---------------------------------------------------------------
   reg [15:0] pin_config_word;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_config_word <= `CFG_RESET;
      end else if (wr_en_i && addr_i == `CFG_ADDR) begin
         // Masked bits stay zero whatever is written
         pin_config_word <= wdata_i & `CFG_WMASK;
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Address-only read with no strobe, so a read never changes state
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else if (addr_i == `CFG_ADDR) begin
         rdata_o <= pin_config_word & `CFG_WMASK;
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // Time-base prescale limit: each step multiplies the period by four
   function [`TICK_W-1:0] tick_limit;
      input [1:0] tb;
      begin
         tick_limit = (`TICK_ONE << (tb * `TB_STEP)) - `TICK_ONE;
      end
   endfunction

   // ---------------------------------------------------------------
   // Per-pin logic
   // ---------------------------------------------------------------
   wire [PINS-1:0] next_pin_drive;
   wire [PINS-1:0] next_pin_oe_n;
   wire [PINS-1:0] next_input_level;
   wire [PINS-1:0] next_readback_level;
   wire [PINS-1:0] next_readback_mismatch;
   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_pin
         wire fmt = pin_config_word[`FMT_LSB+i];
         wire dir = pin_config_word[`DIR_LSB+i];
         // Pin 1 has no alternate, so it always takes output data
         wire src = (i == `PIN1_IDX) ? 1'b1 : pin_config_word[i];
         wire [1:0] tb = time_base_i[2*i+1:2*i];
         wire [`CNT_W-1:0] ll_hc = low_code_high_count_i[`CNT_W*i+:`CNT_W];
         wire [`CNT_W-1:0] ll_lc = low_code_low_count_i[`CNT_W*i+:`CNT_W];
         wire [`CNT_W-1:0] lh_hc = high_code_high_count_i[`CNT_W*i+:`CNT_W];
         wire [`CNT_W-1:0] lh_lc = high_code_low_count_i[`CNT_W*i+:`CNT_W];
         wire data = src ? output_data_i[i] : alt_signal_i[i];
         wire [`CNT_W-1:0] hc = data ? lh_hc : ll_hc;
         wire [`CNT_W-1:0] lc = data ? lh_lc : ll_lc;
         wire [`CNT_W:0] thr_sum = {1'b0, ll_hc} + {1'b0, lh_hc};
         wire [`CNT_W-1:0] thr = thr_sum[`CNT_W:1];
         reg sync1, sync2, prev;
         reg [`TICK_W-1:0] tick_cnt;
         reg phase_high;
         reg [`CNT_W-1:0] gen_cnt;
         reg [`CNT_W-1:0] meas;
         reg pwm_level;
         wire tick = (tick_cnt == tick_limit(tb));
         wire fall = prev & ~sync2;
         // Decoded level: high time nearer the high-code count means 1
         wire decoded = (meas > thr) ^ (ll_hc > lh_hc);
         wire level = fmt ? pwm_level : sync2;
         wire gen_out = fmt ? phase_high : data;

         // ------------------------------------------------------------
         // Pin synchroniser
         // ------------------------------------------------------------
         // Two flops, since the pins change with no regard to this clock
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               sync1 <= 1'b0;
               sync2 <= 1'b0;
               prev <= 1'b0;
            end else begin
               sync1 <= pin_i[i];
               sync2 <= sync1;
               prev <= sync2;
            end
         end

         // ------------------------------------------------------------
         // Time base
         // ------------------------------------------------------------
         // Held at zero in static format, so pulses start on a tick
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               tick_cnt <= {`TICK_W{1'b0}};
            end else if (tick || !fmt) begin
               tick_cnt <= {`TICK_W{1'b0}};
            end else begin
               tick_cnt <= tick_cnt + `TICK_ONE;
            end
         end

         // ------------------------------------------------------------
         // Pulse generator
         // ------------------------------------------------------------
         // A zero count skips that phase
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               phase_high <= 1'b0;
               gen_cnt <= {`CNT_W{1'b0}};
            end else if (!fmt) begin
               phase_high <= 1'b0;
               gen_cnt <= {`CNT_W{1'b0}};
            end else if (tick) begin
               if (phase_high ? (gen_cnt + `CNT_ONE >= hc)
                              : (gen_cnt + `CNT_ONE >= lc)) begin
                  phase_high <= phase_high ? (lc == {`CNT_W{1'b0}})
                                           : (hc != {`CNT_W{1'b0}});
                  gen_cnt <= {`CNT_W{1'b0}};
               end else begin
                  gen_cnt <= gen_cnt + `CNT_ONE;
               end
            end
         end

         // ------------------------------------------------------------
         // Pulse decoder
         // ------------------------------------------------------------
         // Measures high time in time-base ticks
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               meas <= {`CNT_W{1'b0}};
               pwm_level <= 1'b0;
            end else if (!fmt) begin
               meas <= {`CNT_W{1'b0}};
               pwm_level <= 1'b0;
            end else if (fall) begin
               pwm_level <= decoded;
               meas <= {`CNT_W{1'b0}};
            end else if (tick && sync2 && meas != {`CNT_W{1'b1}}) begin
               meas <= meas + `CNT_ONE; // Saturates on long highs
            end
         end

         // ------------------------------------------------------------
         // Next output values
         // ------------------------------------------------------------
         // Input level holds while the pin drives, so software keeps
         // the last level taken before the direction changed
         assign next_pin_drive[i] = gen_out;
         assign next_pin_oe_n[i] = ~dir;
         assign next_input_level[i] = dir ? input_level_o[i] : level;
         assign next_readback_level[i] = dir ? level : 1'b0;
         assign next_readback_mismatch[i] = dir & (level != data);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Pin outputs
   // ---------------------------------------------------------------
   // One process owns each output vector, so no bit has two drivers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_o <= {PINS{1'b0}};
         pin_oe_n_o <= {PINS{1'b1}};
         input_level_o <= {PINS{1'b0}};
         readback_level_o <= {PINS{1'b0}};
         readback_mismatch_o <= {PINS{1'b0}};
      end else begin
         // Registered, so a configuration change lands one cycle on
         pin_o <= next_pin_drive;
         pin_oe_n_o <= next_pin_oe_n;
         input_level_o <= next_input_level;
         readback_level_o <= next_readback_level;
         readback_mismatch_o <= next_readback_mismatch;
      end
   end

endmodule // gpio_format_config

// ==== include/gpio_format_config_defines.vh ====
// Constants for the pin format and direction configuration block.
// Assumes a 16-bit device register map with byte-wide addresses.
`ifndef GPIO_FORMAT_CONFIG_DEFINES_VH
`define GPIO_FORMAT_CONFIG_DEFINES_VH

`define CFG_ADDR 8'h4d
`define CFG_RESET 16'h0000
`define CFG_WMASK 16'h7ffd
`define FMT_LSB 10
`define DIR_LSB 5
`define PIN1_IDX 1
`define CNT_W 7
`define TICK_W 8
`define TB_STEP 2
`define CNT_ONE 7'h01
`define TICK_ONE 8'h01

`endif

// ==== testbench/gpio_format_config_asserts.sv ====
// Checks of the configuration word and static pin paths.
// Assumes binding into gpio_format_config; sees its ports only.
`timescale 1ns/10ps
// ----
// Checker
// ----
module gpio_format_config_asserts #(
   parameter PINS = 5
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] addr_i,
   input wire wr_en_i,
   input wire [15:0] wdata_i,
   input wire [15:0] rdata_o,
   input wire [PINS-1:0] output_data_i,
   input wire [PINS-1:0] pin_i,
   input wire [PINS-1:0] pin_o,
   input wire [PINS-1:0] pin_oe_n_o,
   input wire [PINS-1:0] input_level_o
);
   reg [15:0] cfg;
   wire sel = addr_i == 8'h4d;
   wire st1 = cfg[6] & ~cfg[11];
   wire gp3 = cfg[8] & cfg[3] & ~cfg[13];
   wire in4 = ~cfg[9] & ~cfg[14];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Shadow word, so pin checks need no hidden state
   always @(posedge clk_i or posedge rst_i)
      if (rst_i) cfg <= 16'h0000;
      else if (sel && wr_en_i) cfg <= wdata_i & 16'h7ffd;
   a_top_bit_zero:
      assert property (!rdata_o[15]) else $error("bit 15 set");
   a_spare_bit_zero:
      assert property (!rdata_o[1]) else $error("bit 1 set");
   a_read_word:
      assert property ($past(sel) |-> rdata_o == $past(cfg))
         else $error("word");
   a_unmapped_read:
      assert property (!$past(sel) |-> rdata_o == 16'h0000)
         else $error("read");
   a_dir_enable:
      assert property (pin_oe_n_o == ~$past(cfg[9:5])) else $error("enable");
   a_static_drive:
      assert property ($past(st1) |-> pin_o[1] == $past(output_data_i[1]))
         else $error("pin 1 drive");
   a_source_data:
      assert property ($past(gp3) |-> pin_o[3] == $past(output_data_i[3]))
         else $error("pin 3 drive");
   a_static_input:
      assert property (in4 && $past(in4, 3) |->
         input_level_o[4] == $past(pin_i[4], 3)) else $error("pin 4 level");
   c_word_write: cover property (sel && wr_en_i);
   c_all_driven: cover property (pin_oe_n_o == 5'h00);
   c_pulse_edge: cover property ($rose(pin_o[1]));
endmodule // gpio_format_config_asserts
bind gpio_format_config gpio_format_config_asserts #(.PINS(PINS))
   gpio_format_config_asserts_inst (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .addr_i(addr_i),
   .wr_en_i(wr_en_i),
   .wdata_i(wdata_i),
   .rdata_o(rdata_o),
   .output_data_i(output_data_i),
   .pin_i(pin_i),
   .pin_o(pin_o),
   .pin_oe_n_o(pin_oe_n_o),
   .input_level_o(input_level_o)
);

// ==== testbench/pin_partner.sv ====
// Circuitry on the five pins: loopback of driven pins, set levels else.
// Assumes the bench gives idle levels and a mask of shorted pins.
`timescale 1ns/10ps
// ----
// Partner
// ----
module pin_partner (
   input wire [4:0] drive_i,
   input wire [4:0] drive_en_n_i,
   input wire [4:0] level_i,
   input wire [4:0] short_i,
   output wire [4:0] pin_level_o
);
   // A short flips what the block reads back, as a damaged trace would
   assign pin_level_o = (~drive_en_n_i & (drive_i ^ short_i))
      | (drive_en_n_i & level_i);
endmodule // pin_partner

// ==== testbench/tb.sv ====
// Bench of the pin configuration word and its pin paths.
// Assumes the block, its checker and the pin partner compiled first.
`timescale 1ns/10ps
// ----
// Bench
// ----
module tb;
   reg clk_i = 1'b0, rst_i = 1'b1, wr_en_i = 1'b0;
   reg [7:0] addr_i = 8'h4d;
   reg [15:0] wdata_i = 16'h0000;
   reg [4:0] output_data_i = 5'h00, alt_signal_i = 5'h00;
   reg [4:0] level = 5'h00, short = 5'h00;
   wire [34:0] low_code_high_count_i = {5{7'h00}};
   wire [34:0] low_code_low_count_i = {5{7'h05}};
   wire [34:0] high_code_high_count_i = {5{7'h02}};
   wire [34:0] high_code_low_count_i = {5{7'h03}};
   wire [9:0] time_base_i = 10'h000;
   wire [4:0] pin_i, pin_o, pin_oe_n_o, input_level_o;
   wire [4:0] readback_level_o, readback_mismatch_o;
   wire [15:0] rdata_o;
   integer failures = 0, tests_run = 0, cyc = 0, n;
   always #2.5 clk_i = ~clk_i;
   gpio_format_config gpio_format_config_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .addr_i(addr_i),
      .wr_en_i(wr_en_i),
      .wdata_i(wdata_i),
      .rdata_o(rdata_o),
      .output_data_i(output_data_i),
      .alt_signal_i(alt_signal_i),
      .low_code_high_count_i(low_code_high_count_i),
      .low_code_low_count_i(low_code_low_count_i),
      .high_code_high_count_i(high_code_high_count_i),
      .high_code_low_count_i(high_code_low_count_i),
      .time_base_i(time_base_i),
      .pin_i(pin_i),
      .pin_o(pin_o),
      .pin_oe_n_o(pin_oe_n_o),
      .input_level_o(input_level_o),
      .readback_level_o(readback_level_o),
      .readback_mismatch_o(readback_mismatch_o)
   );
   pin_partner pin_partner_inst (.drive_i(pin_o), .drive_en_n_i(pin_oe_n_o),
      .level_i(level), .short_i(short), .pin_level_o(pin_i));
   task chk(input string name, input logic [15:0] exp, got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("[FAIL] %s exp %h got %h", name, exp, got);
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wr_en_i <= 1'b1;
      wdata_i <= d;
      @(posedge clk_i);
      wr_en_i <= 1'b0;
      addr_i <= 8'h4d;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task t_word;
      chk("reset", 16'h0000, rdata_o);
      wr(8'h4d, 16'hffff);
      chk("mask", 16'h7ffd, rdata_o);
      wr(8'h4c, 16'h0000);
      chk("other", 16'h7ffd, rdata_o);
   endtask
   task t_static;
      @(posedge clk_i);
      output_data_i <= 5'h15;
      wr(8'h4d, 16'h03fd);
      chk("oe", 16'h0000, pin_oe_n_o);
      chk("drive", 16'h0015, pin_o);
      repeat (5) @(negedge clk_i);
      chk("readback", 16'h0015, readback_level_o);
      @(posedge clk_i);
      short <= 5'h04;
      repeat (6) @(negedge clk_i);
      chk("mismatch", 16'h0004, readback_mismatch_o);
      @(posedge clk_i);
      short <= 5'h00;
      output_data_i <= 5'h00;
      alt_signal_i <= 5'h0a;
      wr(8'h4d, 16'h03e0);
      chk("alt", 16'h0008, pin_o);
   endtask
   task t_input;
      @(posedge clk_i);
      level <= 5'h13;
      wr(8'h4d, 16'h0000);
      repeat (3) @(negedge clk_i);
      chk("input", 16'h0013, input_level_o);
   endtask
   task t_pulse;
      @(posedge clk_i);
      output_data_i <= 5'h02;
      wr(8'h4d, 16'h0840);
      repeat (12) @(negedge clk_i);
      n = 0;
      repeat (20) @(negedge clk_i) n = n + pin_o[1];
      chk("highs", 16'h0008, n[15:0]);
      chk("decode", 16'h0002, readback_level_o);
   endtask
   task t_pulse_in;
      @(posedge clk_i);
      level <= 5'h00;
      wr(8'h4d, 16'h4000);
      @(posedge clk_i);
      level <= 5'h10;
      repeat (2) @(posedge clk_i);
      level <= 5'h00;
      repeat (8) @(negedge clk_i);
      chk("wide pulse", 16'h0010, input_level_o);
      @(posedge clk_i);
      level <= 5'h10;
      @(posedge clk_i);
      level <= 5'h00;
      repeat (8) @(negedge clk_i);
      chk("narrow pulse", 16'h0000, input_level_o);
   endtask
   task results;
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         failures = failures + 1;
         results;
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      t_word;
      t_static;
      t_input;
      t_pulse;
      t_pulse_in;
      results;
   end
endmodule // tb
